// ===== include/timer_pwm_pkg.sv
package timer_pwm_pkg;
	// Register indices; the byte address of a register is four times its index.
	localparam logic [7:0] IDX_CTRL = 8'h00;
	localparam logic [7:0] IDX_T0_COUNT = 8'h01;
	localparam logic [7:0] IDX_T1_COUNT = 8'h02;
	localparam logic [7:0] IDX_T2_COUNT = 8'h03;
	localparam logic [7:0] IDX_T3_COUNT = 8'h04;
	localparam logic [7:0] IDX_T0_LOW_RELOAD = 8'h05;
	localparam logic [7:0] IDX_T1_LOW_RELOAD = 8'h06;
	localparam logic [7:0] IDX_T0_HIGH_RELOAD = 8'h07;
	localparam logic [7:0] IDX_T1_HIGH_RELOAD = 8'h08;
	localparam logic [7:0] IDX_T2_RELOAD = 8'h09;
	localparam logic [7:0] IDX_T3_RELOAD = 8'h0A;
	localparam logic [7:0] IDX_PORT_B_DIR = 8'hD6;
	localparam logic [7:0] IDX_PORT_B_SFR = 8'hD7;
	// Control register fields.
	localparam int CTRL_EN0 = 0;
	localparam int CTRL_EN1 = 1;
	localparam int CTRL_EN23 = 2;
	localparam int CTRL_CASCADE = 3;
	localparam int CTRL_RELOAD0 = 4;
	localparam int CTRL_RELOAD1 = 5;
	localparam int CTRL_BITS = 6;
	localparam int PIN_ONE = 1;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int TICK_DIV = 8;
endpackage

// ===== logic/tick_divider.sv
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIV = 8
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// One-cycle count enable.
	output logic tick_o
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] phase;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= '0;
		end else if (phase == LAST) begin
			phase <= '0;
		end else begin
			phase <= phase + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= (phase == LAST);
		end
	end
endmodule

// ===== logic/toggle_pin.sv
`timescale 1ns/1ps
module toggle_pin (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Timeout event and pin routing.
	input wire logic toggle_i,
	input wire logic dir_out_i,
	input wire logic sfr_en_i,
	// Pin drive.
	output logic pin_o,
	output logic pin_oe_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= 1'b0;
		end else if (toggle_i) begin
			pin_o <= ~pin_o;
		end
	end

	// The pin is driven only when both port settings route the toggle to it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_oe_o <= 1'b0;
		end else begin
			pin_oe_o <= dir_out_i & sfr_en_i;
		end
	end
endmodule

// ===== logic/cascadable_timer_pwm_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - Cascaded pair interrupts once: pair two/three as timer two, PWM pair as timer one or zero.
// - Even timer holds low byte, odd high.
// - Timeout reloads count from reload register.
// - Cascaded timers always reload, keep running.
// - Repeated timeout before service goes unflagged.
// - Control write starts from current count.
// - Enabled timers decrement every eighth clock.
// - Independent timers: 8-bit, optional reload.
// - PWM reload words built from byte pairs.
// - PWM alternates low then high reload.
// - Low reload raises one, high raises zero.
// - Timers two and three only cascade.
// - Timer zero timeout toggles output pin.
// - Reset leaves all timers disabled.
module cascadable_timer_pwm_unit (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Interrupt requests, one-cycle pulses, bit n for timer n.
	output logic [3:0] irq_req_o,
	// Port B pin one toggle output.
	output logic port_b_pin_one_o,
	output logic port_b_pin_one_oe_o
);
	import timer_pwm_pkg::*;

	logic [CTRL_BITS-1:0] ctrl;
	logic [7:0] t0_count, t1_count, t2_count, t3_count;
	logic [7:0] t0_low, t1_low, t0_high, t1_high, t2_reload, t3_reload;
	logic [7:0] port_b_dir, port_b_sfr;
	logic low_next;
	logic tick;
	logic [7:0] idx;
	logic wr;
	logic [7:0] wdat;
	logic cascade, run01, run0, run1, run23;
	logic [15:0] dec01, dec23, pwm_reload;
	logic [7:0] dec0, dec1;
	logic to01, to0, to1, to23, timer_zero_interrupt_request, irq1;
	logic [7:0] next_t0, next_t1;
	logic [31:0] next_rdata;

	tick_divider #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	// Bus decode; a write commits at the edge where the master sees ack.
	assign idx = adr_i[9:2];
	assign wr = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	assign wdat = dat_i[7:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (idx)
			IDX_CTRL: next_rdata[CTRL_BITS-1:0] = ctrl;
			IDX_T0_COUNT: next_rdata[7:0] = t0_count;
			IDX_T1_COUNT: next_rdata[7:0] = t1_count;
			IDX_T2_COUNT: next_rdata[7:0] = t2_count;
			IDX_T3_COUNT: next_rdata[7:0] = t3_count;
			IDX_T0_LOW_RELOAD: next_rdata[7:0] = t0_low;
			IDX_T1_LOW_RELOAD: next_rdata[7:0] = t1_low;
			IDX_T0_HIGH_RELOAD: next_rdata[7:0] = t0_high;
			IDX_T1_HIGH_RELOAD: next_rdata[7:0] = t1_high;
			IDX_T2_RELOAD: next_rdata[7:0] = t2_reload;
			IDX_T3_RELOAD: next_rdata[7:0] = t3_reload;
			IDX_PORT_B_DIR: next_rdata[7:0] = port_b_dir;
			IDX_PORT_B_SFR: next_rdata[7:0] = port_b_sfr;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i & stb_i & ~we_i & ~ack_o) begin
			dat_o <= next_rdata;
		end
	end

	// Control and configuration registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= '0;
		end else if (wr && idx == IDX_CTRL) begin
			ctrl <= wdat[CTRL_BITS-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t0_low <= REG_RESET;
			t1_low <= REG_RESET;
			t0_high <= REG_RESET;
			t1_high <= REG_RESET;
			t2_reload <= REG_RESET;
			t3_reload <= REG_RESET;
			port_b_dir <= REG_RESET;
			port_b_sfr <= REG_RESET;
		end else if (wr) begin
			if (idx == IDX_T0_LOW_RELOAD) t0_low <= wdat;
			if (idx == IDX_T1_LOW_RELOAD) t1_low <= wdat;
			if (idx == IDX_T0_HIGH_RELOAD) t0_high <= wdat;
			if (idx == IDX_T1_HIGH_RELOAD) t1_high <= wdat;
			if (idx == IDX_T2_RELOAD) t2_reload <= wdat;
			if (idx == IDX_T3_RELOAD) t3_reload <= wdat;
			if (idx == IDX_PORT_B_DIR) port_b_dir <= wdat;
			if (idx == IDX_PORT_B_SFR) port_b_sfr <= wdat;
		end
	end

	// Counting; a timeout is the decrement that lands on zero.
	assign cascade = ctrl[CTRL_CASCADE];
	assign run01 = cascade & ctrl[CTRL_EN0] & tick;
	assign run0 = ~cascade & ctrl[CTRL_EN0] & tick;
	assign run1 = ~cascade & ctrl[CTRL_EN1] & tick;
	assign run23 = ctrl[CTRL_EN23] & tick;
	assign dec01 = {t1_count, t0_count} - 16'h0001;
	assign dec23 = {t3_count, t2_count} - 16'h0001;
	assign dec0 = t0_count - 8'h01;
	assign dec1 = t1_count - 8'h01;
	assign to01 = run01 & (dec01 == 16'h0000);
	assign to23 = run23 & (dec23 == 16'h0000);
	assign to0 = run0 & (dec0 == 8'h00);
	assign to1 = run1 & (dec1 == 8'h00);
	assign pwm_reload = low_next ? {t1_low, t0_low} : {t1_high, t0_high};
	// Low phase ends on timer zero's request, high phase on timer one's.
	assign timer_zero_interrupt_request = cascade ? (to01 & ~low_next) : to0;
	assign irq1 = cascade ? (to01 & low_next) : to1;

	always_comb begin
		next_t0 = t0_count;
		next_t1 = t1_count;
		if (run01) begin
			{next_t1, next_t0} = to01 ? pwm_reload : dec01;
		end else begin
			if (run0) begin
				next_t0 = (to0 & ctrl[CTRL_RELOAD0]) ? t0_low : dec0;
			end
			if (run1) begin
				next_t1 = (to1 & ctrl[CTRL_RELOAD1]) ? t1_low : dec1;
			end
		end
	end

	// Count writes override counting; control writes never load counts.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t0_count <= REG_RESET;
			t1_count <= REG_RESET;
		end else begin
			t0_count <= (wr && idx == IDX_T0_COUNT) ? wdat : next_t0;
			t1_count <= (wr && idx == IDX_T1_COUNT) ? wdat : next_t1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t2_count <= REG_RESET;
			t3_count <= REG_RESET;
		end else begin
			if (wr && idx == IDX_T2_COUNT) begin
				t2_count <= wdat;
			end else if (run23) begin
				t2_count <= to23 ? t2_reload : dec23[7:0];
			end
			if (wr && idx == IDX_T3_COUNT) begin
				t3_count <= wdat;
			end else if (run23) begin
				t3_count <= to23 ? t3_reload : dec23[15:8];
			end
		end
	end

	// The PWM starts with the low reload; a control write restarts that order.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_next <= 1'b1;
		end else if (wr && idx == IDX_CTRL) begin
			low_next <= 1'b1;
		end else if (to01) begin
			low_next <= ~low_next;
		end
	end

	// Requests are plain pulses; a second timeout before service is not tracked.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_o <= 4'h0;
		end else begin
			irq_req_o <= {1'b0, to23, irq1, timer_zero_interrupt_request};
		end
	end

	toggle_pin u_toggle (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.toggle_i(timer_zero_interrupt_request),
		.dir_out_i(port_b_dir[PIN_ONE]),
		.sfr_en_i(port_b_sfr[PIN_ONE]),
		.pin_o(port_b_pin_one_o),
		.pin_oe_o(port_b_pin_one_oe_o)
	);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_cascade_single;
		run01 |=> (irq_req_o[1:0] != 2'b11) && (irq_req_o[1:0] == 2'b00 || $past(to01));
	endproperty
	a_cascade_single: assert property (p_cascade_single) else $error("double cascade request");

	property p_low_phase;
		to01 && low_next && !wr |=> irq_req_o[1] && !irq_req_o[0]
			&& {t1_count, t0_count} == {t1_low, t0_low};
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("low phase reload wrong");

	property p_alternate;
		to01 && !wr |=> !low_next == $past(low_next) ##0 low_next != $past(low_next);
	endproperty
	a_alternate: assert property (p_alternate) else $error("pwm phase did not alternate");

	property p_t23_reload;
		to23 && !wr |=> irq_req_o[2] && {t3_count, t2_count} == {t3_reload, t2_reload};
	endproperty
	a_t23_reload: assert property (p_t23_reload) else $error("pair reload wrong");

	property p_indep_noreload;
		to1 && !ctrl[CTRL_RELOAD1] && !wr |=> irq_req_o[1] && t1_count == 8'h00;
	endproperty
	a_indep_noreload: assert property (p_indep_noreload) else $error("t1 reloaded");

	property p_ctrl_no_load;
		wr && idx == IDX_CTRL && !tick |=> t0_count == $past(t0_count)
			&& t2_count == $past(t2_count);
	endproperty
	a_ctrl_no_load: assert property (p_ctrl_no_load) else $error("control write loaded");

	property p_tick_period;
		tick |=> !tick [*7] ##1 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick period not eight");

	property p_hold;
		!ctrl[CTRL_EN23] && !wr |=> t2_count == $past(t2_count) && t3_count == $past(t3_count);
	endproperty
	a_hold: assert property (p_hold) else $error("disabled timer moved");

	property p_toggle;
		irq_req_o[0] |-> port_b_pin_one_o != $past(port_b_pin_one_o);
	endproperty
	a_toggle: assert property (p_toggle) else $error("pin did not toggle");

	property p_reset_off;
		@(posedge clk_i) disable iff (1'b0) $past(rst_i) |-> ctrl == '0;
	endproperty
	a_reset_off: assert property (p_reset_off) else $error("timer enabled after reset");

	c_pwm_cycle: cover property (irq_req_o[1] ##[1:1000] irq_req_o[0]);
	c_t23_timeout: cover property (irq_req_o[2]);
	c_pin_driven: cover property (port_b_pin_one_oe_o && irq_req_o[0]);
endmodule

// ===== verif/irq_sink_model.sv
`timescale 1ns/1ps
module irq_sink_model (
	// Clock.
	input wire logic clk_i,
	// Requests from the timer unit.
	input wire logic [3:0] irq_i,
	// Latest request set taken.
	output logic [3:0] last_o
);
	// Keeps the last nonzero request set, as a pending register would.
	initial last_o = 4'h0;
	always @(posedge clk_i) begin
		if (irq_i !== 4'h0) begin
			last_o <= irq_i;
		end
	end
endmodule

// ===== verif/tb_cascadable_timer_pwm_unit.sv
`timescale 1ns/1ps
module tb_cascadable_timer_pwm_unit;
	import timer_pwm_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cyc_i = 0;
	logic stb_i = 0;
	logic we_i = 0;
	logic [9:0] adr_i = 0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 0;
	logic [31:0] dat_o;
	logic ack_o, pin, oe;
	logic [3:0] irq, last;
	logic [7:0] m;
	logic [7:0] rd;
	int errors = 0;
	int comparisons = 0;
	int n;
	int cycle = 0;
	int prev = 0;
	always #5 clk_i = ~clk_i;
	// Free-running edge count; intervals are measured from one request to the next.
	always @(posedge clk_i) cycle <= cycle + 1;
	cascadable_timer_pwm_unit u_cascadable_timer_pwm_unit (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_req_o(irq),
		.port_b_pin_one_o(pin), .port_b_pin_one_oe_o(oe));
	irq_sink_model u_irq_sink_model (.clk_i(clk_i), .irq_i(irq), .last_o(last));
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc_i <= 1;
		stb_i <= 1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		check("ack", 1, k < 50);
		rd = dat_o[7:0];
		cyc_i <= 0;
		stb_i <= 0;
		we_i <= 0;
	endtask
	task automatic rchk(input string s, input logic [7:0] idx, input logic [7:0] e);
		bus(0, idx, 8'h00);
		check(s, e, rd);
	endtask
	task automatic wait_irq(input logic [3:0] e, input int cyc);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (irq === 4'h0 && n < 3000);
		check("irq", e, irq);
		if (cyc > 0) check("interval", cyc, cycle - prev);
		prev = cycle;
		@(posedge clk_i);
		check("model", e, last);
	endtask
	task automatic t_reset;
		rchk("ctrl", IDX_CTRL, 8'h00);
		rchk("unmapped", 8'h20, 8'h00);
		bus(1, IDX_T0_COUNT, 8'h05);
		repeat (40) @(posedge clk_i);
		rchk("idle count", IDX_T0_COUNT, 8'h05);
		$display("done reset");
	endtask
	task automatic t_indep;
		bus(1, IDX_PORT_B_DIR, 8'h02);
		check("oe dir only", 0, oe);
		bus(1, IDX_PORT_B_SFR, 8'h02);
		bus(1, IDX_T0_COUNT, 8'h02);
		bus(1, IDX_T0_LOW_RELOAD, 8'h03);
		bus(1, IDX_CTRL, 8'h11);
		wait_irq(4'h1, 0);
		check("oe", 1, oe);
		check("pin", 1, pin);
		rchk("reload", IDX_T0_COUNT, 8'h03);
		wait_irq(4'h1, 24);
		check("pin", 0, pin);
		bus(1, IDX_CTRL, 8'h00);
		bus(0, IDX_T0_COUNT, 8'h00);
		m = rd;
		repeat (30) @(posedge clk_i);
		rchk("held", IDX_T0_COUNT, m);
		bus(1, IDX_T1_COUNT, 8'h01);
		bus(1, IDX_CTRL, 8'h02);
		wait_irq(4'h2, 0);
		rchk("no reload", IDX_T1_COUNT, 8'h00);
		bus(1, IDX_CTRL, 8'h00);
		$display("done independent");
	endtask
	task automatic t_pwm;
		bus(1, IDX_T0_COUNT, 8'h01);
		bus(1, IDX_T1_COUNT, 8'h00);
		bus(1, IDX_T0_LOW_RELOAD, 8'h02);
		bus(1, IDX_T1_LOW_RELOAD, 8'h00);
		bus(1, IDX_T0_HIGH_RELOAD, 8'h01);
		bus(1, IDX_T1_HIGH_RELOAD, 8'h00);
		bus(1, IDX_CTRL, 8'h09);
		wait_irq(4'h2, 0);
		rchk("low word", IDX_T0_COUNT, 8'h02);
		wait_irq(4'h1, 16);
		wait_irq(4'h2, 8);
		$display("done pwm");
	endtask
	task automatic t_pair;
		bus(1, IDX_CTRL, 8'h00);
		bus(1, IDX_T2_COUNT, 8'h00);
		bus(1, IDX_T3_COUNT, 8'h01);
		bus(1, IDX_T2_RELOAD, 8'h05);
		bus(1, IDX_T3_RELOAD, 8'h00);
		bus(1, IDX_CTRL, 8'h04);
		wait_irq(4'h4, 0);
		check("full count", 1, n > 255 * 8);
		wait_irq(4'h4, 40);
		$display("done pair");
	endtask
	task automatic close_out;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 0;
		t_reset();
		t_indep();
		t_pwm();
		t_pair();
		close_out();
	end
endmodule
